// ---- design/sgr_pkg.sv ----
// Shared constants, types and helpers for software-raised interrupt routing
`default_nettype none
package sgr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NCORE = 8;
  localparam int CORE_W = 3;
  localparam int NID = 16;
  localparam int ID_W = 4;
  localparam int DATA_W = 64;
  localparam int NSACR_W = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Generation register field layout
  localparam int AFF3_HI = 55;
  localparam int AFF3_LO = 48;
  localparam int RMODE_BIT = 40;
  localparam int AFF2_HI = 39;
  localparam int AFF2_LO = 32;
  localparam int ID_HI = 27;
  localparam int ID_LO = 24;
  localparam int AFF1_HI = 23;
  localparam int AFF1_LO = 16;
  localparam int LIST_LO = 0;

  // Affinity 3.2.1 shared by every connected core; affinity 0 is the core index
  localparam logic [23:0] CORE_AFF_UPPER = 24'h000000;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and access-control encodings
  localparam logic ROUTE_EN_RESET = 1'b1;
  localparam logic [NSACR_W-1:0] NSACR_NONE = 2'h0;
  localparam logic [NSACR_W-1:0] NSACR_G0 = 2'h1;
  localparam logic [NSACR_W-1:0] NSACR_G0_G1 = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    SEL_G0 = 2'h0,
    SEL_G1_CUR = 2'h1,
    SEL_G1_OTH = 2'h2
  } sgr_sel_e;

  typedef enum logic [1:0] {
    CLS_SG0 = 2'h0,
    CLS_SG1 = 2'h1,
    CLS_NSG1 = 2'h2
  } sgr_cls_e;

  typedef struct packed {
    logic valid;
    sgr_sel_e sel;
    logic [CORE_W-1:0] sender;
    logic secure;
    logic [DATA_W-1:0] data;
  } sgr_wr_s;

  typedef struct packed {
    logic valid;
    logic en_ns;
    logic en_s;
  } sgr_cfg_s;

  typedef struct packed {
    logic valid;
    logic [CORE_W-1:0] core;
    logic secure;
    logic [NSACR_W-1:0] value;
  } sgr_nsacr_s;

  typedef struct packed {
    logic valid;
    logic [CORE_W-1:0] core;
    logic [ID_W-1:0] id;
  } sgr_ack_s;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [CORE_W-1:0] sender;
  } sgr_ackr_s;

  typedef struct packed {
    logic valid;
    logic [CORE_W-1:0] core;
    logic secure;
  } sgr_rd_s;

  typedef struct packed {
    logic valid;
    logic [NID-1:0] data;
  } sgr_rdr_s;

  typedef struct packed {
    logic found;
    logic [CORE_W-1:0] idx;
  } sgr_low_s;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic sgr_cls_e core_class(input logic grp, input logic modif);
    if (grp) begin
      return CLS_NSG1;
    end
    return modif ? CLS_SG1 : CLS_SG0;
  endfunction

  function automatic logic ns_may_g0(input logic [NSACR_W-1:0] n);
    return (n == NSACR_G0) || (n == NSACR_G0_G1);
  endfunction

  function automatic logic ns_may_g1(input logic [NSACR_W-1:0] n);
    return n == NSACR_G0_G1;
  endfunction

  function automatic logic ns_visible(input sgr_cls_e c, input logic [NSACR_W-1:0] n);
    return (c == CLS_NSG1) || ((c == CLS_SG0) && ns_may_g0(n)) ||
           ((c == CLS_SG1) && ns_may_g1(n));
  endfunction

  function automatic sgr_low_s lowest_set(input logic [NCORE-1:0] v);
    sgr_low_s r;
    r = '0;
    for (int k = NCORE - 1; k >= 0; k--) begin
      if (v[k]) begin
        r.found = 1'b1;
        r.idx = CORE_W'(k);
      end
    end
    return r;
  endfunction

endpackage
`default_nettype wire

// ---- design/sgr_fwd.sv ----
// Forward-or-drop decision for one target core
`default_nettype none
module sgr_fwd
  import sgr_pkg::*;
(
  input wire sgr_sel_e sel,
  input wire logic sender_secure,
  input wire logic grp_sel,
  input wire logic grp_mod,
  input wire logic [NSACR_W-1:0] nsacr,
  input wire logic sec_disable,
  output logic fwd
);

  sgr_cls_e cls;
  logic g0_ok;
  logic g1_ok;

  // Receiver class and what a non-secure sender may reach
  always_comb begin
    cls = core_class(grp_sel, grp_mod);
    g0_ok = ns_may_g0(nsacr) || sec_disable;
    g1_ok = ns_may_g1(nsacr);
  end

  // Forwarding matrix, one register at a time
  always_comb begin
    fwd = 1'b0;
    if (sender_secure) begin
      // Secure side reaches both worlds, on exact match except group 1 current to group 0 under security disable
      case (sel)
        SEL_G0: fwd = (cls == CLS_SG0);
        SEL_G1_CUR: fwd = (cls == CLS_SG1) || ((cls == CLS_SG0) && sec_disable);
        SEL_G1_OTH: fwd = (cls == CLS_NSG1);
        default: fwd = 1'b0;
      endcase
    end else begin
      case (sel)
        SEL_G0: fwd = (cls == CLS_SG0) && g0_ok;
        SEL_G1_CUR: begin
          fwd = (cls == CLS_NSG1) || ((cls == CLS_SG0) && g0_ok) ||
                ((cls == CLS_SG1) && g1_ok);
        end
        SEL_G1_OTH: begin
          // Other-state group 1 never lands on non-secure group 1 here
          fwd = ((cls == CLS_SG0) && g0_ok) || ((cls == CLS_SG1) && g1_ok);
        end
        default: fwd = 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- design/sgr_top.sv ----
// Software-raised interrupt generation, routing and per-target pending state
`default_nettype none
module sgr_top
  import sgr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire sgr_wr_s gen_wr,
  input wire sgr_cfg_s route_wr,
  input wire sgr_nsacr_s nsacr_wr,
  input wire sgr_ack_s ack_req,
  input wire sgr_rd_s rd_req,
  input wire logic [NCORE-1:0][NID-1:0] target_group_select,
  input wire logic [NCORE-1:0][NID-1:0] target_group_modifier,
  input wire logic security_disable_bit,
  output logic [NCORE-1:0][NID-1:0] pending,
  output sgr_ackr_s ack_resp,
  output sgr_rdr_s rd_resp,
  output logic [NCORE-1:0][NSACR_W-1:0] nonsecure_access_control,
  output logic routing_enable_nonsecure,
  output logic routing_enable_secure
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  sgr_wr_s req_reg, req_next;
  logic route_ns_reg, route_ns_next;
  logic route_s_reg, route_s_next;
  logic [NCORE-1:0][NSACR_W-1:0] nsacr_reg, nsacr_next;
  logic [NCORE-1:0][NID-1:0][NCORE-1:0] bank_reg, bank_next;
  logic [NCORE-1:0][NID-1:0] pend_reg, pend_next;
  sgr_ackr_s ackr_reg, ackr_next;
  sgr_rdr_s rdr_reg, rdr_next;

  logic rmode;
  logic [ID_W-1:0] req_id;
  logic upper_match;
  logic legacy;
  logic [NCORE-1:0] tgt_mask;
  logic [NCORE-1:0] fwd_vec;
  logic [NCORE-1:0] set_mask;
  logic [CORE_W-1:0] slot;
  sgr_low_s low;

  ////////////////////////////////////////////////////////////////////////////
  // Request capture; the registers are write-only, nothing reads them back
  always_comb begin
    req_next = gen_wr;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      req_reg <= '0;
    end else begin
      req_reg <= req_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration: routing enables and per-target access control
  always_comb begin
    route_ns_next = route_ns_reg;
    route_s_next = route_s_reg;
    nsacr_next = nsacr_reg;
    // Secure-on with nonsecure-off is refused so the pair never goes illegal
    if (route_wr.valid && !(route_wr.en_s && !route_wr.en_ns)) begin
      route_ns_next = route_wr.en_ns;
      route_s_next = route_wr.en_s;
    end
    // Non-secure attempts are dropped silently
    if (nsacr_wr.valid && nsacr_wr.secure) begin
      nsacr_next[nsacr_wr.core] = nsacr_wr.value;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      route_ns_reg <= ROUTE_EN_RESET;
      route_s_reg <= ROUTE_EN_RESET;
      nsacr_reg <= '0;
    end else begin
      route_ns_reg <= route_ns_next;
      route_s_reg <= route_s_next;
      nsacr_reg <= nsacr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target decode from the captured write
  always_comb begin
    rmode = req_reg.data[RMODE_BIT];
    req_id = req_reg.data[ID_HI:ID_LO];
    upper_match = {req_reg.data[AFF3_HI:AFF3_LO], req_reg.data[AFF2_HI:AFF2_LO],
                   req_reg.data[AFF1_HI:AFF1_LO]} == CORE_AFF_UPPER;
    // Only bits for real cores are looked at; higher list bits fall away
    for (int t = 0; t < NCORE; t++) begin
      if (rmode) begin
        tgt_mask[t] = (CORE_W'(t) != req_reg.sender);
      end else begin
        tgt_mask[t] = upper_match && req_reg.data[LIST_LO + t];
      end
    end
  end

  // One forwarding decision per target core
  for (genvar g = 0; g < NCORE; g++) begin : g_fwd
    sgr_fwd u_fwd (
      .sel(req_reg.sel),
      .sender_secure(req_reg.secure),
      .grp_sel(target_group_select[g][req_id]),
      .grp_mod(target_group_modifier[g][req_id]),
      .nsacr(nsacr_reg[g]),
      .sec_disable(security_disable_bit),
      .fwd(fwd_vec[g])
    );
  end

  always_comb begin
    set_mask = tgt_mask & fwd_vec & {NCORE{req_reg.valid}};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending banks, acknowledge and status read
  always_comb begin
    legacy = !route_ns_reg;
    bank_next = bank_reg;
    ackr_next = '0;
    low = lowest_set(bank_reg[ack_req.core][ack_req.id]);
    // Clear first so a set in the same cycle wins
    if (ack_req.valid) begin
      ackr_next.valid = 1'b1;
      if (legacy) begin
        ackr_next.hit = low.found;
        ackr_next.sender = low.idx;
        if (low.found) begin
          bank_next[ack_req.core][ack_req.id][low.idx] = 1'b0;
        end
      end else begin
        // Whole vector cleared: leftovers from legacy banks cannot linger
        ackr_next.hit = |bank_reg[ack_req.core][ack_req.id];
        bank_next[ack_req.core][ack_req.id] = '0;
      end
    end
    // Affinity mode folds every sender into slot zero
    slot = legacy ? req_reg.sender : '0;
    for (int t = 0; t < NCORE; t++) begin
      if (set_mask[t]) begin
        bank_next[t][req_id][slot] = 1'b1;
      end
    end
    for (int t = 0; t < NCORE; t++) begin
      for (int i = 0; i < NID; i++) begin
        pend_next[t][i] = |bank_next[t][i];
      end
    end
    // Status read, masked for non-secure readers
    rdr_next.valid = rd_req.valid;
    for (int i = 0; i < NID; i++) begin
      rdr_next.data[i] = rd_req.valid && pend_reg[rd_req.core][i] && (rd_req.secure ||
        ns_visible(core_class(target_group_select[rd_req.core][i],
                              target_group_modifier[rd_req.core][i]),
                   nsacr_reg[rd_req.core]));
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bank_reg <= '0;
      pend_reg <= '0;
      ackr_reg <= '0;
      rdr_reg <= '0;
    end else begin
      bank_reg <= bank_next;
      pend_reg <= pend_next;
      ackr_reg <= ackr_next;
      rdr_reg <= rdr_next;
    end
  end

  // Outputs straight from flops
  assign pending = pend_reg;
  assign ack_resp = ackr_reg;
  assign rd_resp = rdr_reg;
  assign nonsecure_access_control = nsacr_reg;
  assign routing_enable_nonsecure = route_ns_reg;
  assign routing_enable_secure = route_s_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_route_combo_legal: assert property (
    !(route_s_reg && !route_ns_reg)
  ) else $error("illegal routing enable pair");

  a_nsacr_secure_only: assert property (
    nsacr_wr.valid && !nsacr_wr.secure |=> $stable(nsacr_reg)
  ) else $error("access control changed by non-secure write");

  a_broadcast_skip_self: assert property (
    req_reg.valid && rmode |-> !set_mask[req_reg.sender]
  ) else $error("broadcast reached its sender");

  a_ack_merge_clear: assert property (
    ack_req.valid && !legacy && !(set_mask[ack_req.core] && req_id == ack_req.id)
    |=> !pend_reg[$past(ack_req.core)][$past(ack_req.id)]
  ) else $error("acknowledged merged interrupt still pending");

  a_legacy_prefix: assert property (
    ack_req.valid && legacy && low.found |=> ack_resp.hit && ack_resp.sender == $past(low.idx)
  ) else $error("legacy acknowledge lost sender number");

  // Every identifier watched, not just one, so the read scenario reaches it
  for (genvar i = 0; i < NID; i++) begin : g_rd_chk
    a_ns_read_hidden: assert property (
      rd_req.valid && !rd_req.secure && nsacr_reg[rd_req.core] == NSACR_NONE &&
      !target_group_select[rd_req.core][i] |=> !rd_resp.data[i]
    ) else $error("secure state shown to non-secure read");
  end

  for (genvar t = 0; t < NCORE; t++) begin : g_chk
    a_set_then_pending: assert property (
      set_mask[t] |=> pend_reg[t][$past(req_id)] ##1 (pend_reg[t] != '0 || $past(ack_req.valid))
    ) else $error("delivered interrupt not pending");

    a_list_targets: assert property (
      req_reg.valid && !rmode && upper_match && req_reg.data[LIST_LO + t] |-> tgt_mask[t]
    ) else $error("listed core not targeted");

    a_secure_g0_match: assert property (
      req_reg.valid && req_reg.secure && req_reg.sel == SEL_G0 &&
      target_group_select[t][req_id] |-> !set_mask[t]
    ) else $error("secure group 0 write reached group 1 target");

    a_ns_other_drop: assert property (
      req_reg.valid && !req_reg.secure && req_reg.sel == SEL_G1_OTH &&
      target_group_select[t][req_id] |=> !$rose(pend_reg[t][$past(req_id)])
    ) else $error("non-secure other-state write reached non-secure group 1");

    a_disable_fwd_g0: assert property (
      req_reg.valid && security_disable_bit && req_reg.sel == SEL_G1_CUR &&
      !target_group_select[t][req_id] && !target_group_modifier[t][req_id] |-> fwd_vec[t]
    ) else $error("security disable did not forward group 0 case");
  end

  c_broadcast: cover property (req_reg.valid && rmode && set_mask != '0);
  c_legacy_double: cover property (legacy && $countones(bank_reg[0][0]) > 1);
  c_ack_hit: cover property (ack_resp.valid && ack_resp.hit);
  c_ns_dropped: cover property (req_reg.valid && !req_reg.secure && tgt_mask != '0 &&
                                set_mask == '0);

endmodule
`default_nettype wire

// ---- tb/sgr_pe_model.sv ----
// Partner model: processing elements writing the generation registers
`default_nettype none
module sgr_pe_model
  import sgr_pkg::*;
(
  input wire logic mclk,
  output sgr_wr_s gen_wr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial gen_wr = '0;

  ////////////////////////////////////////////////////////////////////////////
  // One generation write, launched after a falling edge, one cycle wide
  task automatic send(input sgr_sel_e sel, input logic [CORE_W-1:0] who, input logic sec,
                      input logic [ID_W-1:0] id, input logic mode, input logic [7:0] aff1,
                      input logic [15:0] list);
    sgr_wr_s w;
    w = '0;
    w.valid = 1'b1;
    w.sel = sel;
    w.sender = who;
    w.secure = sec;
    w.data[ID_HI:ID_LO] = id;
    w.data[RMODE_BIT] = mode;
    w.data[AFF1_HI:AFF1_LO] = aff1;
    w.data[LIST_LO+15:LIST_LO] = list;
    @(negedge mclk);
    gen_wr <= w;
    @(negedge mclk);
    // Idle bus shows inverted data so a stale word is never mistaken for a write
    w.valid = 1'b0;
    w.data = ~w.data;
    gen_wr <= w;
  endtask
endmodule
`default_nettype wire

// ---- tb/sgr_top_tb_top.sv ----
// Self-checking bench for software-raised interrupt routing
`default_nettype none
module sgr_top_tb_top
  import sgr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    sgr_sel_e sel;
    logic sec;
    sgr_cls_e cls;
    logic [1:0] ns;
    logic ds;
    logic fwd;
  } sgr_row_s;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  sgr_wr_s gen_wr;
  sgr_cfg_s route_wr = '0;
  sgr_nsacr_s nsacr_wr = '0;
  sgr_ack_s ack_req = '0;
  sgr_rd_s rd_req = '0;
  logic [NCORE-1:0][NID-1:0] grp_sel = '1;
  logic [NCORE-1:0][NID-1:0] grp_mod = '0;
  logic sec_dis = 1'b0;
  logic [NCORE-1:0][NID-1:0] pending;
  sgr_ackr_s ack_resp;
  sgr_rdr_s rd_resp;
  logic [NCORE-1:0][NSACR_W-1:0] nsacr;
  logic en_ns;
  logic en_s;
  int fails = 0;
  int num_checks = 0;

  // Forwarding matrix: register, sender state, receiver class, access control, disable
  sgr_row_s rows [24] = '{
    '{SEL_G0, 1'b1, CLS_SG0, 2'h0, 1'b0, 1'b1}, '{SEL_G0, 1'b1, CLS_SG1, 2'h0, 1'b0, 1'b0},
    '{SEL_G0, 1'b1, CLS_NSG1, 2'h0, 1'b0, 1'b0}, '{SEL_G1_CUR, 1'b1, CLS_SG0, 2'h0, 1'b0, 1'b0},
    '{SEL_G1_CUR, 1'b1, CLS_SG0, 2'h0, 1'b1, 1'b1}, '{SEL_G1_CUR, 1'b1, CLS_SG1, 2'h0, 1'b0, 1'b1},
    '{SEL_G1_CUR, 1'b1, CLS_NSG1, 2'h0, 1'b0, 1'b0}, '{SEL_G1_OTH, 1'b1, CLS_SG0, 2'h0, 1'b0, 1'b0},
    '{SEL_G1_OTH, 1'b1, CLS_SG1, 2'h0, 1'b0, 1'b0}, '{SEL_G1_OTH, 1'b1, CLS_NSG1, 2'h0, 1'b0, 1'b1},
    '{SEL_G0, 1'b0, CLS_SG0, 2'h0, 1'b0, 1'b0}, '{SEL_G0, 1'b0, CLS_SG0, 2'h1, 1'b0, 1'b1},
    '{SEL_G0, 1'b0, CLS_SG0, 2'h0, 1'b1, 1'b1}, '{SEL_G0, 1'b0, CLS_SG1, 2'h2, 1'b0, 1'b0},
    '{SEL_G0, 1'b0, CLS_NSG1, 2'h2, 1'b0, 1'b0}, '{SEL_G1_CUR, 1'b0, CLS_SG0, 2'h0, 1'b0, 1'b0},
    '{SEL_G1_CUR, 1'b0, CLS_SG0, 2'h2, 1'b0, 1'b1}, '{SEL_G1_CUR, 1'b0, CLS_SG1, 2'h1, 1'b0, 1'b0},
    '{SEL_G1_CUR, 1'b0, CLS_SG1, 2'h2, 1'b0, 1'b1}, '{SEL_G1_CUR, 1'b0, CLS_NSG1, 2'h0, 1'b0, 1'b1},
    '{SEL_G1_OTH, 1'b0, CLS_SG0, 2'h0, 1'b1, 1'b1}, '{SEL_G1_OTH, 1'b0, CLS_SG1, 2'h2, 1'b0, 1'b1},
    '{SEL_G1_OTH, 1'b0, CLS_NSG1, 2'h2, 1'b0, 1'b0}, '{SEL_G0, 1'b1, CLS_SG1, 2'h0, 1'b1, 1'b0}
  };

  always #20 mclk = ~mclk;

  sgr_top i_sgr_top (
    .mclk(mclk),
    .rst(rst),
    .gen_wr(gen_wr),
    .route_wr(route_wr),
    .nsacr_wr(nsacr_wr),
    .ack_req(ack_req),
    .rd_req(rd_req),
    .target_group_select(grp_sel),
    .target_group_modifier(grp_mod),
    .security_disable_bit(sec_dis),
    .pending(pending),
    .ack_resp(ack_resp),
    .rd_resp(rd_resp),
    .nonsecure_access_control(nsacr),
    .routing_enable_nonsecure(en_ns),
    .routing_enable_secure(en_s)
  );

  sgr_pe_model i_sgr_pe_model (
    .mclk(mclk),
    .gen_wr(gen_wr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and register-side tasks
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Settle an extra cycle so the written value is visible before any compare
  task automatic put_nsacr(input logic [CORE_W-1:0] c, input logic sec, input logic [1:0] v);
    @(negedge mclk);
    nsacr_wr <= '{1'b1, c, sec, v};
    @(negedge mclk);
    nsacr_wr <= '0;
    @(negedge mclk);
  endtask

  task automatic route(input logic ns, input logic s);
    @(negedge mclk);
    route_wr <= '{1'b1, ns, s};
    @(negedge mclk);
    route_wr <= '0;
    @(negedge mclk);
  endtask

  // Sender is only meaningful on a hit, so it is masked out otherwise
  task automatic ack(input logic [CORE_W-1:0] c, input logic [ID_W-1:0] id, input logic hit,
                     input logic [CORE_W-1:0] who);
    @(negedge mclk);
    ack_req <= '{1'b1, c, id};
    @(negedge mclk);
    ack_req <= '0;
    for (int k = 0; k < 3 && ack_resp.valid !== 1'b1; k++) @(negedge mclk);
    chk("ack_resp", {1'b1, hit, hit ? who : 3'h0},
        {ack_resp.valid, ack_resp.hit, hit ? ack_resp.sender : 3'h0});
  endtask

  task automatic rd(input logic [CORE_W-1:0] c, input logic sec, input logic [15:0] exp);
    @(negedge mclk);
    rd_req <= '{1'b1, c, sec};
    @(negedge mclk);
    rd_req <= '0;
    for (int k = 0; k < 3 && rd_resp.valid !== 1'b1; k++) @(negedge mclk);
    chk("rd_resp", {1'b1, exp}, rd_resp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: whole sequence needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    logic [NCORE-1:0][NID-1:0] e;
    repeat (3) @(negedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk("pending", '0, pending);
    chk("route_en", 2'h3, {en_ns, en_s});
    chk("nsacr", '0, nsacr);
    // Table rows: sender 1 targets core 2 through its list bit
    foreach (rows[r]) begin
      sec_dis <= rows[r].ds;
      grp_sel[2][r % 16] <= rows[r].cls == CLS_NSG1;
      grp_mod[2][r % 16] <= rows[r].cls == CLS_SG1;
      put_nsacr(3'h2, 1'b1, rows[r].ns);
      i_sgr_pe_model.send(rows[r].sel, 3'h1, rows[r].sec, ID_W'(r), 1'b0, 8'h00, 16'h0004);
      repeat (3) @(negedge mclk);
      e = '0;
      e[2][r % 16] = rows[r].fwd;
      chk("pending", e, pending);
      if (rows[r].fwd) begin
        ack(3'h2, ID_W'(r), 1'b1, 3'h0);
      end
    end
    sec_dis <= 1'b0;
    grp_sel <= '1;
    grp_mod <= '0;
    // Broadcast from core 3 with junk in the ignored fields
    i_sgr_pe_model.send(SEL_G1_CUR, 3'h3, 1'b0, 4'h7, 1'b1, 8'h05, 16'h0001);
    repeat (3) @(negedge mclk);
    e = '0;
    for (int c = 0; c < NCORE; c++) e[c][7] = (c != 3);
    chk("pending", e, pending);
    for (int c = 0; c < NCORE; c++) if (c != 3) ack(CORE_W'(c), 4'h7, 1'b1, 3'h0);
    // Wrong affinity 1, absent cores only, then a list that includes the sender
    i_sgr_pe_model.send(SEL_G1_CUR, 3'h0, 1'b0, 4'h6, 1'b0, 8'h01, 16'hFFFF);
    i_sgr_pe_model.send(SEL_G1_CUR, 3'h0, 1'b0, 4'h6, 1'b0, 8'h00, 16'hFF00);
    repeat (3) @(negedge mclk);
    chk("pending", '0, pending);
    i_sgr_pe_model.send(SEL_G1_CUR, 3'h0, 1'b0, 4'h6, 1'b0, 8'h00, 16'h0005);
    repeat (3) @(negedge mclk);
    e = '0;
    e[0][6] = 1'b1;
    e[2][6] = 1'b1;
    chk("pending", e, pending);
    ack(3'h0, 4'h6, 1'b1, 3'h0);
    ack(3'h2, 4'h6, 1'b1, 3'h0);
    // Two senders merge into one pending; a resend after acknowledge counts again
    i_sgr_pe_model.send(SEL_G1_CUR, 3'h2, 1'b0, 4'h4, 1'b0, 8'h00, 16'h0010);
    i_sgr_pe_model.send(SEL_G1_CUR, 3'h6, 1'b0, 4'h4, 1'b0, 8'h00, 16'h0010);
    repeat (3) @(negedge mclk);
    ack(3'h4, 4'h4, 1'b1, 3'h0);
    ack(3'h4, 4'h4, 1'b0, 3'h0);
    i_sgr_pe_model.send(SEL_G1_CUR, 3'h2, 1'b0, 4'h4, 1'b0, 8'h00, 16'h0010);
    repeat (3) @(negedge mclk);
    chk("pending", 1'b1, pending[4][4]);
    ack(3'h4, 4'h4, 1'b1, 3'h0);
    // Secure group 0 state hidden from non-secure reads until permitted
    grp_sel[5][9] <= 1'b0;
    i_sgr_pe_model.send(SEL_G0, 3'h1, 1'b1, 4'h9, 1'b0, 8'h00, 16'h0020);
    repeat (3) @(negedge mclk);
    rd(3'h5, 1'b0, 16'h0000);
    rd(3'h5, 1'b1, 16'h0200);
    put_nsacr(3'h5, 1'b0, 2'h2);
    chk("nsacr", 2'h0, nsacr[5]);
    put_nsacr(3'h5, 1'b1, 2'h1);
    chk("nsacr", 2'h1, nsacr[5]);
    rd(3'h5, 1'b0, 16'h0200);
    ack(3'h5, 4'h9, 1'b1, 3'h0);
    // Illegal enable pair is refused; legacy mode banks by sender
    route(1'b0, 1'b1);
    chk("route_en", 2'h3, {en_ns, en_s});
    route(1'b0, 1'b0);
    chk("route_en", 2'h0, {en_ns, en_s});
    i_sgr_pe_model.send(SEL_G1_CUR, 3'h6, 1'b0, 4'h3, 1'b0, 8'h00, 16'h0002);
    i_sgr_pe_model.send(SEL_G1_CUR, 3'h5, 1'b0, 4'h3, 1'b0, 8'h00, 16'h0002);
    repeat (3) @(negedge mclk);
    ack(3'h1, 4'h3, 1'b1, 3'h5);
    chk("pending", 1'b1, pending[1][3]);
    ack(3'h1, 4'h3, 1'b1, 3'h6);
    chk("pending", 1'b0, pending[1][3]);
    ack(3'h1, 4'h3, 1'b0, 3'h0);
    route(1'b1, 1'b1);
    chk("route_en", 2'h3, {en_ns, en_s});
    tally_and_finish();
  end
endmodule
`default_nettype wire
